// >>> hw/vfb_map.vh
// vfb_map.vh: constants for the frame-buffer memory controller
// assumes inclusion by bare name from the design files
`ifndef VFB_MAP_VH
`define VFB_MAP_VH
`define VFB_ADDR_W 17
`define VFB_ROW_W 9
`define VFB_COL_LSB 0
`define VFB_ROW_LSB 8
`define VFB_PIX_PER_ROW 2048
`define VFB_PIX_PER_ACCESS 8
`define VFB_DATA_W 64
`define VFB_PRECHARGE_CYC 3
`define VFB_FIFO_DEPTH 16
`define VFB_SER_HALF_CYC 4
`endif

// >>> hw/vfb_fifo.v
// vfb_fifo.v: synchronous fifo for read and write requests
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module vfb_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk,
    input wire rst_n,
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wrPtr_r;
    reg [AW:0] rdPtr_r;
    wire empty = (wrPtr_r == rdPtr_r);
    wire full = (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]) && (wrPtr_r[AW] != rdPtr_r[AW]);
    assign inReady = !full;
    assign outValid = !empty;
    assign outData = mem[rdPtr_r[AW-1:0]];
    always @(posedge clk) begin
        if (inValid && !full)
            mem[wrPtr_r[AW-1:0]] <= inData;
    end
    always @(posedge clk) begin
        if (!rst_n) begin
            wrPtr_r <= {(AW+1){1'b0}};
            rdPtr_r <= {(AW+1){1'b0}};
        end else begin
            if (inValid && !full)
                wrPtr_r <= wrPtr_r + {{AW{1'b0}}, 1'b1};
            if (outReady && !empty)
                rdPtr_r <= rdPtr_r + {{AW{1'b0}}, 1'b1};
        end
    end
endmodule
`default_nettype wire

// >>> hw/vfb_ctrl.v
// vfb_ctrl.v: frame-buffer memory controller driving eight 128k x 8 video memories
// assumes requests in the 50 MHz clock domain; memory pins are registered outputs
`timescale 1ns/1ps
`default_nettype none
`include "vfb_map.vh"
// Notes on behaviour
// - The address spans one megabyte of eight 128k-by-8 chips, one 1152x900 buffer.
// - Each access drives column strobe, row strobe, eight pixel write enables and address.
// - Eight pixels move per access over a 64-bit bus of eight byte lanes.
// - One nine-bit address bus is shared by all memory chips.
// - The address bus carries the row first and the column after it.
// - A new memory row begins every 2048 pixels.
// - A random access presents both a row and a column address.
// - Same-row consecutive accesses use fast page, giving only a new column.
// - A row change costs three more cycles than a fast-page access.
module vfb_ctrl #(
    parameter ADDR_W = `VFB_ADDR_W,
    parameter DATA_W = `VFB_DATA_W,
    parameter FIFO_DEPTH = `VFB_FIFO_DEPTH
) (
    input wire clk,
    input wire rst_n,
    input wire reqValid,
    output wire reqReady,
    input wire reqWrite,
    input wire [ADDR_W-1:0] reqAddr,
    input wire [7:0] reqPixMask,
    input wire [DATA_W-1:0] reqData,
    output reg rdValid,
    output reg [DATA_W-1:0] rdData,
    input wire serialStart,
    output reg serialBusy,
    output reg [8:0] mem_addr_mux,
    output reg row_strobe_n,
    output reg col_strobe_n,
    output reg [7:0] pixWriteEn_n,
    output reg outEn_n,
    input wire [DATA_W-1:0] pixelDataIn,
    output reg [DATA_W-1:0] pixel_data_bus,
    output reg pixelDataOe,
    output reg serial_out_en_lo,
    output reg serial_out_en_hi
);
    localparam ST_IDLE = 3'd0;
    localparam ST_PRE = 3'd1;
    localparam ST_ROW = 3'd2;
    localparam ST_COL = 3'd3;
    localparam ST_DATA = 3'd4;
    localparam ST_END = 3'd5;
    localparam REQ_W = 1 + ADDR_W + 8 + DATA_W;
    localparam FIFO_AW = $clog2(FIFO_DEPTH);
    localparam ROW_LSB = `VFB_ROW_LSB;
    localparam LANES = `VFB_PIX_PER_ACCESS;
    // precharge spans the two ST_PRE cycles and the ST_ROW cycle
    localparam [1:0] PRE_LAST = `VFB_PRECHARGE_CYC - 2;
    // each serial enable stands for a fixed count; no refresh is interleaved
    localparam [2:0] SER_LAST = `VFB_SER_HALF_CYC - 1;
    function isIdle(input [2:0] st);
        isIdle = (st == ST_IDLE);
    endfunction
    wire fValid;
    wire fReady;
    wire [REQ_W-1:0] fData;
    vfb_fifo #(.WIDTH(REQ_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) reqFifo (
        .clk(clk),
        .rst_n(rst_n),
        .inValid(reqValid),
        .inReady(reqReady),
        .inData({reqWrite, reqAddr, reqPixMask, reqData}),
        .outValid(fValid),
        .outReady(fReady),
        .outData(fData)
    );
    wire fWrite = fData[REQ_W-1];
    wire [ADDR_W-1:0] fAddr = fData[REQ_W-2 -: ADDR_W];
    wire [7:0] fMask = fData[DATA_W+7 -: 8];
    wire [DATA_W-1:0] fWdata = fData[DATA_W-1:0];
    // addr counts 8-pixel words: low 8 bits column, upper 9 bits row (2048 pixels per row)
    wire [8:0] fRow = fAddr[ROW_LSB +: 9];
    wire [7:0] fCol = fAddr[ROW_LSB-1:0];
    reg [2:0] state_r;
    reg [8:0] openRow_r;
    reg rowOpen_r;
    reg [1:0] cnt_r;
    reg curWrite_r;
    reg [7:0] curCol_r;
    reg [7:0] curMask_r;
    reg [DATA_W-1:0] curData_r;
    // lane i carries pixel i, so each lane's enable follows its own mask bit
    wire [LANES-1:0] laneWe_n;
    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : gLane
            assign laneWe_n[g] = ~(curWrite_r & curMask_r[g]);
        end
    endgenerate
    wire pageHit = rowOpen_r && (openRow_r == fRow);
    // pop on entry so the fifo can refill while the memory cycle runs
    // a waiting serial transfer takes the idle slot first; held high it stalls requests
    wire serialGo = serialStart && isIdle(state_r) && !serialBusy;
    assign fReady = isIdle(state_r) && !serialBusy && !serialStart;
    always @(posedge clk) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            openRow_r <= 9'h000;
            rowOpen_r <= 1'b0;
            cnt_r <= 2'h0;
            curWrite_r <= 1'b0;
            curCol_r <= 8'h00;
            curMask_r <= 8'hff;
            curData_r <= {DATA_W{1'b0}};
            mem_addr_mux <= 9'h000;
            row_strobe_n <= 1'b1;
            col_strobe_n <= 1'b1;
            pixWriteEn_n <= 8'hff;
            outEn_n <= 1'b1;
            pixel_data_bus <= {DATA_W{1'b0}};
            pixelDataOe <= 1'b0;
            rdValid <= 1'b0;
            rdData <= {DATA_W{1'b0}};
        end else begin
            rdValid <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    col_strobe_n <= 1'b1;
                    pixWriteEn_n <= 8'hff;
                    outEn_n <= 1'b1;
                    pixelDataOe <= 1'b0;
                    if (fValid && fReady) begin
                        curWrite_r <= fWrite;
                        curCol_r <= fCol;
                        curMask_r <= fMask;
                        curData_r <= fWdata;
                        if (pageHit) begin
                            state_r <= ST_COL;
                        end else begin
                            // close old row and precharge: three extra cycles
                            row_strobe_n <= 1'b1;
                            openRow_r <= fRow;
                            rowOpen_r <= 1'b1;
                            cnt_r <= 2'h0;
                            state_r <= ST_PRE;
                        end
                    end
                end
                ST_PRE: begin
                    mem_addr_mux <= openRow_r;
                    cnt_r <= cnt_r + 2'h1;
                    if (cnt_r == PRE_LAST) begin
                        state_r <= ST_ROW;
                    end
                end
                ST_ROW: begin
                    // memory latches row on this fall; enables update plane mask
                    row_strobe_n <= 1'b0;
                    pixWriteEn_n <= 8'h00;
                    state_r <= ST_COL;
                end
                ST_COL: begin
                    pixWriteEn_n <= 8'hff;
                    mem_addr_mux <= {1'b0, curCol_r};
                    pixel_data_bus <= curData_r;
                    pixelDataOe <= curWrite_r;
                    outEn_n <= curWrite_r;
                    state_r <= ST_DATA;
                end
                ST_DATA: begin
                    col_strobe_n <= 1'b0;
                    pixWriteEn_n <= laneWe_n;
                    state_r <= ST_END;
                end
                ST_END: begin
                    if (!curWrite_r) begin
                        rdData <= pixelDataIn;
                        rdValid <= 1'b1;
                    end
                    col_strobe_n <= 1'b1;
                    pixWriteEn_n <= 8'hff;
                    outEn_n <= 1'b1;
                    state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end
    // serial transfer: low group for pixels 0..3, then high group for 4..7
    reg [2:0] serCnt_r;
    reg serPhase_r;
    always @(posedge clk) begin
        if (!rst_n) begin
            serialBusy <= 1'b0;
            serCnt_r <= 3'h0;
            serPhase_r <= 1'b0;
            serial_out_en_lo <= 1'b0;
            serial_out_en_hi <= 1'b0;
        end else if (!serialBusy) begin
            if (serialGo) begin
                serialBusy <= 1'b1;
                serPhase_r <= 1'b0;
                serCnt_r <= 3'h0;
                serial_out_en_lo <= 1'b1;
            end
        end else begin
            serCnt_r <= serCnt_r + 3'h1;
            if (serCnt_r == SER_LAST) begin
                serCnt_r <= 3'h0;
                if (!serPhase_r) begin
                    serPhase_r <= 1'b1;
                    serial_out_en_lo <= 1'b0;
                    serial_out_en_hi <= 1'b1;
                end else begin
                    serial_out_en_hi <= 1'b0;
                    serialBusy <= 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> testbench/vfb_ctrl_checker.sv
// vfb_ctrl_checker.sv: port-level assertions for the frame-buffer controller
// assumes the design's single clock and synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module vfb_ctrl_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rdValid,
    input wire logic serialBusy,
    input wire logic [8:0] mem_addr_mux,
    input wire logic row_strobe_n,
    input wire logic col_strobe_n,
    input wire logic outEn_n,
    input wire logic pixelDataOe,
    input wire logic serial_out_en_lo,
    input wire logic serial_out_en_hi
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_RDPULSE: assert property (rdValid |=> !rdValid)
        else $error("read valid held too long");
    AST_RSTIDLE: assert property ($rose(rst_n) |-> row_strobe_n && col_strobe_n)
        else $error("strobes active after reset");
    AST_ROWADDR: assert property ($fell(row_strobe_n) |-> $stable(mem_addr_mux))
        else $error("address moved at row strobe fall");
    AST_COLADDR: assert property ($fell(col_strobe_n) |-> $stable(mem_addr_mux))
        else $error("address moved at column strobe fall");
    AST_COLROW: assert property (!col_strobe_n |-> !row_strobe_n)
        else $error("column strobe without open row");
    AST_PRECH: assert property ($rose(row_strobe_n) |-> row_strobe_n[*3])
        else $error("row precharge too short");
    AST_DIR: assert property (!(pixelDataOe && !outEn_n))
        else $error("pixel bus driven by both sides");
    AST_SERSEQ: assert property ($rose(serial_out_en_lo) |-> serial_out_en_lo[*4] ##1
        serial_out_en_hi[*4] ##1 !serial_out_en_hi) else $error("serial enable sequence wrong");
    AST_SERMEM: assert property (serialBusy |-> col_strobe_n)
        else $error("memory column cycle during serial transfer");
    AST_SERONE: assert property (!(serial_out_en_lo && serial_out_en_hi))
        else $error("both serial enables active");
endmodule
bind vfb_ctrl vfb_ctrl_checker chk (.clk(clk), .rst_n(rst_n), .rdValid(rdValid),
    .serialBusy(serialBusy), .mem_addr_mux(mem_addr_mux), .row_strobe_n(row_strobe_n),
    .col_strobe_n(col_strobe_n),
    .outEn_n(outEn_n), .pixelDataOe(pixelDataOe), .serial_out_en_lo(serial_out_en_lo),
    .serial_out_en_hi(serial_out_en_hi));
`default_nettype wire

// >>> testbench/vfb_vram_model.sv
// vfb_vram_model.sv: behavioural bank of video memories on the shared address bus
// assumes registered strobes from the controller, sampled on the rising clock
`timescale 1ns/1ps
`default_nettype none
module vfb_vram_model (
    input wire logic clk,
    input wire logic [8:0] mem_addr_mux,
    input wire logic row_strobe_n,
    input wire logic col_strobe_n,
    input wire logic [7:0] pixWriteEn_n,
    input wire logic outEn_n,
    input wire logic [63:0] pixel_data_bus,
    output logic [63:0] pixelDataIn
);
    logic [63:0] mem [0:131071];
    logic [63:0] merged;
    logic [8:0] rowR;
    logic rowPrev = 1;
    logic tg = 0;
    wire logic [16:0] key = {rowR, mem_addr_mux[7:0]};
    // released bus toggles each cycle so a stale capture cannot match
    assign pixelDataIn = (!outEn_n && !col_strobe_n) ? mem[key] : {64{tg}};
    // merge enabled lanes first so the stored word is written once per edge
    always_comb begin
        merged = mem[key];
        for (int i = 0; i < 8; i++)
            if (!pixWriteEn_n[i]) merged[i*8+:8] = pixel_data_bus[i*8+:8];
    end
    always @(posedge clk) begin
        tg <= ~tg;
        rowPrev <= row_strobe_n;
        if (rowPrev && !row_strobe_n) rowR <= mem_addr_mux;
        if (!col_strobe_n && pixWriteEn_n != 8'hff) mem[key] <= merged;
    end
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// tb_top.sv: self-checking bench for the frame-buffer controller
// assumes the memory model answers reads from what was written
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 0, rst_n = 0, reqValid = 0, reqWrite = 0, serialStart = 0, sawFull = 0;
    logic [16:0] reqAddr = 0;
    logic [7:0] reqPixMask = 0;
    logic [63:0] reqData = 0;
    wire logic reqReady, rdValid, serialBusy, row_strobe_n, col_strobe_n, outEn_n, pixelDataOe;
    wire logic serial_out_en_lo, serial_out_en_hi;
    wire logic [8:0] mem_addr_mux;
    wire logic [7:0] pixWriteEn_n;
    wire logic [63:0] rdData, pixelDataIn, pixel_data_bus;
    int n_mismatch = 0, checks = 0;
    int nLo = 0, nHi = 0;
    logic [31:0] rnd = 32'h16e0;
    logic [63:0] shadow [logic [16:0]];
    logic [63:0] expQ [$];
    logic [16:0] adr [8];
    always #10 clk = ~clk;
    vfb_ctrl dut (.clk(clk), .rst_n(rst_n), .reqValid(reqValid), .reqReady(reqReady),
        .reqWrite(reqWrite), .reqAddr(reqAddr), .reqPixMask(reqPixMask), .reqData(reqData),
        .rdValid(rdValid), .rdData(rdData), .serialStart(serialStart), .serialBusy(serialBusy),
        .mem_addr_mux(mem_addr_mux), .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
        .pixWriteEn_n(pixWriteEn_n), .outEn_n(outEn_n), .pixelDataIn(pixelDataIn),
        .pixel_data_bus(pixel_data_bus), .pixelDataOe(pixelDataOe),
        .serial_out_en_lo(serial_out_en_lo), .serial_out_en_hi(serial_out_en_hi));
    vfb_vram_model vram (.clk(clk), .mem_addr_mux(mem_addr_mux), .row_strobe_n(row_strobe_n),
        .col_strobe_n(col_strobe_n), .pixWriteEn_n(pixWriteEn_n), .outEn_n(outEn_n),
        .pixel_data_bus(pixel_data_bus), .pixelDataIn(pixelDataIn));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task complete_run;
        if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // request held from just after an edge until ready is seen at a falling edge, then through the next rising edge
    task req(input logic w, input logic [16:0] a, input logic [7:0] m, input logic [63:0] d);
        logic rdy;
        #1;
        reqValid = 1;
        reqWrite = w;
        reqAddr = a;
        reqPixMask = m;
        reqData = d;
        rdy = 0;
        while (rdy !== 1'b1) begin
            @(negedge clk);
            rdy = reqReady;
            if (rdy !== 1'b1) sawFull = 1;
            @(posedge clk);
        end
        if (w) begin
            for (int i = 0; i < 8; i++) if (m[i]) shadow[a][i*8+:8] = d[i*8+:8];
        end else expQ.push_back(shadow[a]);
    endtask
    always @(negedge clk) if (serialBusy === 1'b1) begin
        if (serial_out_en_hi === 1'b1) chk(64'(nLo), 64'h4);
        nLo += int'(serial_out_en_lo === 1'b1);
        nHi += int'(serial_out_en_hi === 1'b1);
    end
    always @(negedge clk) if (rdValid === 1'b1) begin
        if (expQ.size() == 0) chk(rdData, 64'hx);
        else chk(rdData, expQ.pop_front());
    end
    initial begin
        wait (rst_n);
        repeat (30) @(posedge clk);
        #1 serialStart = 1;
        do @(negedge clk); while (serialBusy !== 1'b1);
        @(posedge clk);
        #1 serialStart = 0;
    end
    initial begin
        #200000;
        n_mismatch++;
        complete_run;
    end
    initial begin
        repeat (4) @(posedge clk);
        #1 rst_n = 1;
        @(posedge clk);
        // first two straddle a row boundary, then the third is a same-row hit
        for (int k = 0; k < 8; k++) begin
            rnd = lfsr(rnd);
            adr[k] = k < 3 ? 17'h000ff + 17'(k) : rnd[16:0];
        end
        for (int p = 0; p < 3; p++) for (int k = 0; k < 8; k++) begin
            rnd = lfsr(rnd);
            req(p != 2, adr[k], p == 0 ? 8'hff : rnd[7:0], {rnd, lfsr(rnd)});
        end
        for (int j = 0; j < 20; j++) req(0, adr[j % 8], 8'h00, 64'h0);
        #1 reqValid = 0;
        for (int t = 0; t < 2000 && expQ.size() > 0; t++) @(posedge clk);
        chk(64'(sawFull), 64'h1);
        chk(64'(expQ.size()), 64'h0);
        chk(64'(nLo), 64'h4);
        chk(64'(nHi), 64'h4);
        complete_run;
    end
endmodule
`default_nettype wire
